// ==== rtl/drs_pkg.sv ====
// Package of the refresh scheduler: register offset, field layout, reset value, types.
// Assumes one 48-bit control register written as a whole word with byte enables.
package drs_pkg;

  localparam logic [11:0] CTRL_OFFSET     = 12'h269;
  localparam int          CTRL_W          = 48;
  localparam logic [47:0] CTRL_RESET      = 48'h021830000c30;
  // Writable bits; reserved bits 47:42, 26 and 21:20 read as zero.
  localparam logic [47:0] CTRL_WMASK      = 48'h03fffbcfffff;

  localparam int DIRECT_QUIET_LSB   = 37;
  localparam int INDIRECT_QUIET_LSB = 32;
  localparam int COMP_WAIT_LSB      = 27;
  localparam int CNT_ENABLE_BIT     = 25;
  localparam int ALL_RANK_BIT       = 24;
  localparam int ISSUE_ENABLE_BIT   = 23;
  localparam int INIT_DONE_BIT      = 22;
  localparam int PANIC_WM_LSB       = 18;
  localparam int HIGH_WM_LSB        = 16;
  localparam int LOW_WM_LSB         = 14;
  localparam int INTERVAL_LSB       = 0;
  localparam int INTERVAL_W         = 14;
  localparam int WINDOW_W           = 5;
  localparam int WM_W               = 2;
  localparam int SPACING_W          = 9;
  localparam int PENDING_W          = 4;

  // Watermark field codes are offsets from these base levels.
  localparam logic [3:0] LOW_WM_BASE   = 4'h1;
  localparam logic [3:0] HIGH_WM_BASE  = 4'h3;
  localparam logic [3:0] PANIC_WM_BASE = 4'h5;
  localparam logic [3:0] PENDING_MAX   = 4'hf;

  typedef struct packed {
    logic [WINDOW_W-1:0]   direct_comp_quiet_window;
    logic [WINDOW_W-1:0]   indirect_comp_quiet_window;
    logic [WINDOW_W-1:0]   comp_service_wait;
    logic                  reserved_26;
    logic                  interval_counter_enable;
    logic                  all_rank_refresh_select;
    logic                  refresh_issue_enable;
    logic                  memory_init_complete;
    logic [1:0]            reserved_21_20;
    logic [WM_W-1:0]       refresh_panic_watermark;
    logic [WM_W-1:0]       refresh_high_watermark;
    logic [WM_W-1:0]       refresh_low_watermark;
    logic [INTERVAL_W-1:0] refresh_interval_count;
  } drs_cfg_s;

  typedef enum logic [2:0] {
    COMP_IDLE  = 3'b001,
    COMP_WAIT  = 3'b010,
    COMP_QUIET = 3'b100
  } drs_comp_e;

endpackage : drs_pkg

// ==== rtl/drs_interval_timer.sv ====
// Refresh interval timer: emits a one-cycle tick every terminal count plus one clocks.
// Assumes the terminal count is stable while running; a smaller value takes effect at once.
`timescale 1ns/1ps
module drs_interval_timer #(
  parameter int W = 14
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // Control
  input  wire logic         run_in,
  input  wire logic [W-1:0] terminal_in,
  // Tick
  output logic              tick_out
);

  logic [W-1:0] count;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      count    <= '0;
      tick_out <= 1'b0;
    end
    else if (!run_in)
    begin
      count    <= '0;
      tick_out <= 1'b0;
    end
    else if (count >= terminal_in)
    begin
      count    <= '0; // R1
      tick_out <= 1'b1;
    end
    else
    begin
      count    <= count + 1'b1;
      tick_out <= 1'b0;
    end
  end

endmodule : drs_interval_timer

// ==== rtl/drs_refresh_scheduler.sv ====
// Refresh scheduler of one DRAM channel: control register, pending count, watermark
// requests, rank sequencing, same-rank spacing and compensation wait windows.
// Assumes the scheduler pulses refresh_done_in only while a request is shown.
//
// Operation
// R1: Interval counter wraps at 14-bit timeout field.
// R2: Software loads timeout per memory clock rate.
// R3: Pending above low watermark requests, low flag.
// R4: Pending above high watermark requests, high flag.
// R5: Pending above panic watermark requests, panic flag.
// R6: Issue enable runs counter and issues refreshes.
// R7: Counter enable alone accumulates without issuing.
// R8: Both disabled: no issue, no accumulation.
// R9: All-rank staggered default, else independent ranks.
// R10: Read/write init-complete bit, reset zero.
// R11: Per-rank mode waits ticks before compensation.
// R12: Same-rank refreshes spaced by programmed clocks.
// R13: Count up per tick, down per refresh.
`timescale 1ns/1ps
module drs_refresh_scheduler #(
  parameter int NUM_RANKS = 2,
  parameter int RANK_W    = 1
) (
  // Clock and reset
  input  wire logic                          clk_in,
  input  wire logic                          rst_in,
  // Register port
  input  wire logic                          reg_wr_in,
  input  wire logic [5:0]                    reg_be_in,
  input  wire logic [drs_pkg::CTRL_W-1:0]    reg_wdata_in,
  output logic      [drs_pkg::CTRL_W-1:0]    reg_rdata_out,
  // Spacing from the cycle tracker
  input  wire logic [drs_pkg::SPACING_W-1:0] spacing_in,
  // Scheduler refresh handshake
  output logic                               refresh_req_out,
  output logic                               refresh_all_out,
  output logic      [RANK_W-1:0]             refresh_rank_out,
  output logic                               urgency_low_out,
  output logic                               urgency_high_out,
  output logic                               urgency_panic_out,
  input  wire logic                          refresh_done_in,
  // Compensation handshake
  input  wire logic                          comp_req_in,
  input  wire logic                          comp_direct_in,
  output logic                               comp_grant_out,
  // Status
  output logic      [drs_pkg::PENDING_W-1:0] pending_out,
  output logic                               init_done_out
);

  logic [drs_pkg::CTRL_W-1:0]    ctrl;
  drs_pkg::drs_cfg_s             cfg;
  logic                          tick;
  logic                          counter_run;
  logic [drs_pkg::PENDING_W-1:0] pending;
  logic [drs_pkg::SPACING_W-1:0] spacing_left [NUM_RANKS];
  logic [RANK_W-1:0]             rank_ptr;
  logic [NUM_RANKS-1:0]          rank_ready;
  logic                          spacing_ok;
  logic [3:0]                    low_level;
  logic [3:0]                    high_level;
  logic [3:0]                    panic_level;
  logic                          refresh_taken;
  logic                          sweep_done;
  drs_pkg::drs_comp_e            comp_state;
  logic [drs_pkg::WINDOW_W-1:0]  comp_count;
  logic                          quiet;

  function automatic logic [3:0] wm_level(input logic [3:0] base, input logic [1:0] code);
    wm_level = base + {2'b00, code};
  endfunction : wm_level

  assign cfg = drs_pkg::drs_cfg_s'(ctrl[41:0]);

  // Byte-enabled writes; read-only bits keep their zero value.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      ctrl <= drs_pkg::CTRL_RESET; // R10
    else if (reg_wr_in)
    begin
      for (int b = 0; b < 6; b++)
        if (reg_be_in[b])
          ctrl[b*8 +: 8] <= reg_wdata_in[b*8 +: 8] & drs_pkg::CTRL_WMASK[b*8 +: 8];
    end
  end

  assign reg_rdata_out = ctrl;
  assign init_done_out = cfg.memory_init_complete; // R10

  assign counter_run = cfg.refresh_issue_enable | cfg.interval_counter_enable; // R6 R7 R8

  drs_interval_timer #(
    .W           (drs_pkg::INTERVAL_W)
  ) u_timer (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .run_in      (counter_run),
    .terminal_in (cfg.refresh_interval_count), // R1
    .tick_out    (tick)
  );

  assign low_level   = wm_level(drs_pkg::LOW_WM_BASE, cfg.refresh_low_watermark);
  assign high_level  = wm_level(drs_pkg::HIGH_WM_BASE, cfg.refresh_high_watermark);
  assign panic_level = wm_level(drs_pkg::PANIC_WM_BASE, cfg.refresh_panic_watermark);

  always_comb
  begin
    for (int r = 0; r < NUM_RANKS; r++)
      rank_ready[r] = (spacing_left[r] == '0);
  end

  // All-rank mode waits for every rank to be clear of spacing so the sweep stays atomic.
  assign spacing_ok = cfg.all_rank_refresh_select ? rank_ready[rank_ptr] : &rank_ready; // R9 R12

  assign urgency_low_out   = pending > low_level; // R3
  assign urgency_high_out  = pending > high_level; // R4
  assign urgency_panic_out = pending > panic_level; // R5
  // A quiet window holds back routine refreshes, never a panic.
  assign refresh_req_out   = cfg.refresh_issue_enable & spacing_ok
                             & (urgency_panic_out | (urgency_low_out & !quiet)); // R3 R4 R5 R7 R8 R13
  assign refresh_all_out   = !cfg.all_rank_refresh_select; // R9
  assign refresh_rank_out  = rank_ptr;
  assign refresh_taken     = refresh_req_out & refresh_done_in;
  assign sweep_done        = refresh_taken
                             & (!cfg.all_rank_refresh_select || rank_ptr == RANK_W'(NUM_RANKS - 1));
  assign pending_out       = pending;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      rank_ptr <= '0;
    else if (!cfg.all_rank_refresh_select)
      rank_ptr <= '0;
    else if (refresh_taken)
      rank_ptr <= (rank_ptr == RANK_W'(NUM_RANKS - 1)) ? '0 : rank_ptr + 1'b1; // R9
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      for (int r = 0; r < NUM_RANKS; r++)
        spacing_left[r] <= '0;
    else
      for (int r = 0; r < NUM_RANKS; r++)
        if (refresh_taken && (!cfg.all_rank_refresh_select || rank_ptr == RANK_W'(r)))
          spacing_left[r] <= (spacing_in == '0) ? '0 : spacing_in - 1'b1; // R12
        else if (spacing_left[r] != '0)
          spacing_left[r] <= spacing_left[r] - 1'b1;
  end

  // A tick and a completed sweep in the same cycle cancel out.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      pending <= '0;
    else if (tick && counter_run && !sweep_done)
    begin
      if (pending != drs_pkg::PENDING_MAX)
        pending <= pending + 1'b1; // R13 R7
    end
    else if (sweep_done && !(tick && counter_run) && pending != '0)
      pending <= pending - 1'b1; // R13
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      comp_state     <= drs_pkg::COMP_IDLE;
      comp_count     <= '0;
      comp_grant_out <= 1'b0;
    end
    else
    begin
      comp_grant_out <= 1'b0;
      case (comp_state)
        drs_pkg::COMP_IDLE:
          if (comp_req_in)
          begin
            if (!cfg.all_rank_refresh_select)
              comp_grant_out <= 1'b1;
            else if (cfg.comp_service_wait == '0)
            begin
              comp_grant_out <= 1'b1;
              comp_count     <= comp_direct_in ? cfg.direct_comp_quiet_window : cfg.indirect_comp_quiet_window;
              comp_state     <= drs_pkg::COMP_QUIET;
            end
            else
            begin
              comp_count <= cfg.comp_service_wait; // R11
              comp_state <= drs_pkg::COMP_WAIT;
              // Direct versus indirect is not stored; comp_direct_in is sampled again when the wait ends.
            end
          end
        drs_pkg::COMP_WAIT:
          if (tick)
          begin
            if (comp_count == 5'h01)
            begin
              comp_grant_out <= 1'b1; // R11
              comp_count     <= comp_direct_in ? cfg.direct_comp_quiet_window : cfg.indirect_comp_quiet_window;
              comp_state     <= drs_pkg::COMP_QUIET;
            end
            else
              comp_count <= comp_count - 1'b1;
          end
        drs_pkg::COMP_QUIET:
          if (comp_count == '0)
            comp_state <= drs_pkg::COMP_IDLE;
          else if (tick)
            comp_count <= comp_count - 1'b1; // R11
        default:
          comp_state <= drs_pkg::COMP_IDLE;
      endcase
    end
  end

  assign quiet = (comp_state == drs_pkg::COMP_QUIET);

  property p_req_needs_issue;
    @(posedge clk_in) disable iff (rst_in)
    refresh_req_out |-> cfg.refresh_issue_enable;
  endproperty
  a_req_needs_issue: assert property (p_req_needs_issue) else $error("Refresh requested while issue disabled."); // R7

  property p_no_accumulate;
    @(posedge clk_in) disable iff (rst_in)
    (!cfg.refresh_issue_enable && !cfg.interval_counter_enable) [*2] |=> $stable(pending);
  endproperty
  a_no_accumulate: assert property (p_no_accumulate) else $error("Pending count moved while fully disabled."); // R8

  property p_low_request;
    @(posedge clk_in) disable iff (rst_in)
    (cfg.refresh_issue_enable && pending > low_level && spacing_ok && !quiet) |-> refresh_req_out && urgency_low_out;
  endproperty
  a_low_request: assert property (p_low_request) else $error("Low watermark request missing."); // R3

  property p_high_flag;
    @(posedge clk_in) disable iff (rst_in)
    // Software may set the low level above the high one; only then can low lag high.
    (urgency_high_out && low_level <= high_level) |-> urgency_low_out && pending >= high_level + 4'h1;
  endproperty
  a_high_flag: assert property (p_high_flag) else $error("High flag without pending above high level."); // R4

  property p_panic_request;
    @(posedge clk_in) disable iff (rst_in)
    (cfg.refresh_issue_enable && pending > panic_level && spacing_ok) |-> refresh_req_out && urgency_panic_out;
  endproperty
  a_panic_request: assert property (p_panic_request) else $error("Panic request missing."); // R5

  property p_spacing;
    @(posedge clk_in) disable iff (rst_in)
    (refresh_taken && !cfg.all_rank_refresh_select && spacing_in > 9'h002) |=> !refresh_req_out [*2];
  endproperty
  a_spacing: assert property (p_spacing) else $error("Refresh issued inside same-rank spacing."); // R12

  property p_tick_counts;
    @(posedge clk_in) disable iff (rst_in)
    (tick && counter_run && !sweep_done && pending < drs_pkg::PENDING_MAX) |=> pending == $past(pending) + 4'h1;
  endproperty
  a_tick_counts: assert property (p_tick_counts) else $error("Interval tick not accumulated."); // R13

  property p_run_when_issuing;
    @(posedge clk_in) disable iff (rst_in)
    (cfg.refresh_issue_enable && cfg.refresh_interval_count == 14'h0003) [*5]
      |-> tick || $past(tick) || $past(tick, 2) || $past(tick, 3);
  endproperty
  a_run_when_issuing: assert property (p_run_when_issuing) else $error("Interval counter stalled while issuing."); // R6

  property p_comp_wait;
    @(posedge clk_in) disable iff (rst_in)
    (comp_state == drs_pkg::COMP_IDLE && comp_req_in && cfg.all_rank_refresh_select
     && cfg.comp_service_wait != '0) |=> !comp_grant_out && comp_state == drs_pkg::COMP_WAIT;
  endproperty
  a_comp_wait: assert property (p_comp_wait) else $error("Compensation granted without wait."); // R11

  property p_all_rank;
    @(posedge clk_in) disable iff (rst_in)
    !cfg.all_rank_refresh_select |-> refresh_all_out && rank_ptr == '0;
  endproperty
  a_all_rank: assert property (p_all_rank) else $error("All-rank mode not signalled."); // R9

endmodule : drs_refresh_scheduler

// ==== testbench/drs_sched_model.sv ====
// Model of the channel command scheduler: answers a refresh request with a done pulse.
// Assumes the request is a level held until the pending count drops; the delay sets how slow it is.
`timescale 1ns/1ps
module drs_sched_model (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Request side
  input  wire logic       req_in,
  input  wire logic       enable_in,
  input  wire logic [3:0] delay_in,
  output logic            done_out
);
  logic [3:0] wait_cnt;

  // A done pulse is only given while a request is shown, never unasked.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wait_cnt <= 4'h0;
      done_out <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      if (!(req_in && enable_in) || done_out)
        wait_cnt <= 4'h0;
      else if (wait_cnt >= delay_in)
        done_out <= 1'b1;
      else
        wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule : drs_sched_model

// ==== testbench/dram_refresh_scheduler_ctrl_test.sv ====
// Self-checking bench of the refresh scheduler with a scheduler model on its request side.
// Assumes inputs change at the falling edge and the design registers on the rising edge.
`timescale 1ns/1ps
module dram_refresh_scheduler_ctrl_test;
  typedef struct {logic [47:0] wdata; logic [5:0] be; logic [47:0] exp;} drs_row_s;
  logic        clk, rst, wr, req, all, rank, ulow, uhigh, upanic, done, creq, cdir, cgrant, init_done, m_en;
  logic [5:0]  be;
  logic [47:0] wdata, rdata;
  logic [8:0]  spacing;
  logic [3:0]  pending, p1, m_delay;
  int          bad_count, compares, cycles, nd, gmin, same;
  drs_row_s    rows [5];

  drs_refresh_scheduler #(.NUM_RANKS(2), .RANK_W(1)) u_drs_refresh_scheduler (
    .clk_in(clk), .rst_in(rst), .reg_wr_in(wr), .reg_be_in(be), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .spacing_in(spacing), .refresh_req_out(req), .refresh_all_out(all),
    .refresh_rank_out(rank), .urgency_low_out(ulow), .urgency_high_out(uhigh),
    .urgency_panic_out(upanic), .refresh_done_in(done), .comp_req_in(creq),
    .comp_direct_in(cdir), .comp_grant_out(cgrant), .pending_out(pending), .init_done_out(init_done));
  drs_sched_model u_drs_sched_model (
    .clk_in(clk), .rst_in(rst), .req_in(req), .enable_in(m_en), .delay_in(m_delay), .done_out(done));

  always #50 clk = ~clk;
  // Whole run needs well under a thousand cycles.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      finish_test();
    end
  end

  task automatic check(input string name, input logic [47:0] exp, input logic [47:0] got);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic write_reg(input logic [47:0] data, input logic [5:0] bytes);
    wdata = data;
    be = bytes;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask : write_reg

  // Mode bits are {count enable, independent ranks, issue enable}; watermarks {panic, high, low}.
  function automatic logic [47:0] cfg(input logic [13:0] tmo, input logic [5:0] wm, input logic [2:0] mode,
                                      input logic [4:0] cw);
    cfg = 48'h0;
    cfg[13:0] = tmo;
    cfg[19:14] = wm;
    cfg[25:23] = mode;
    cfg[31:27] = cw;
  endfunction : cfg

  task automatic wait_cycles(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_cycles

  // Lets the model drain pending refreshes, noting done gaps and done pulses on rank 1.
  task automatic drain();
    int last;
    nd = 0;
    gmin = 1000;
    same = 0;
    last = 0;
    for (int i = 0; i < 300 && !(req === 1'b0 && pending === 4'h1); i++)
    begin
      @(negedge clk);
      if (done === 1'b1)
      begin
        if (nd > 0 && i - last < gmin)
          gmin = i - last;
        if (rank === 1'b1)
          same++;
        last = i;
        nd++;
      end
    end
  endtask : drain

  task automatic finish_test();
    $display("Counts: %0d compares, %0d mismatches", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    {wr, creq, cdir, m_en} = 4'h0;
    {be, wdata, spacing, m_delay} = '0;
    rows[0] = '{48'hffffffffffff, 6'h3f, 48'h03fffbcfffff};
    rows[1] = '{48'h000000000820, 6'h3f, 48'h000000000820};
    rows[2] = '{48'h000000000a28, 6'h3f, 48'h000000000a28};
    rows[3] = '{48'h000000400c30, 6'h3f, 48'h000000400c30};
    rows[4] = '{48'hffffffffffff, 6'h01, 48'h000000400cff};
    wait_cycles(3);
    rst = 1'b0;
    check("reset_rdata", drs_pkg::CTRL_RESET, rdata);
    check("reset_all", 48'h1, {47'h0, all});
    check("reset_pending", 48'h0, {44'h0, pending});
    $display("Test reset done");
    foreach (rows[i])
    begin
      write_reg(rows[i].wdata, rows[i].be);
      check("rdata", rows[i].exp, rdata);
      check("init_done", {47'h0, rows[i].exp[22]}, {47'h0, init_done});
    end
    $display("Test register table done");
    write_reg(cfg(14'h3, 6'h0, 3'b100, 5'h0), 6'h3f);
    wait_cycles(2);
    p1 = pending;
    wait_cycles(8);
    check("count_only_pending", {44'h0, p1 + 4'h2}, {44'h0, pending});
    check("count_only_req", 48'h0, {47'h0, req});
    wait_cycles(20);
    write_reg(cfg(14'h3, 6'h0, 3'b000, 5'h0), 6'h3f);
    p1 = pending;
    wait_cycles(12);
    check("off_pending", {44'h0, p1}, {44'h0, pending});
    check("off_req", 48'h0, {47'h0, req});
    for (int c = 0; c < 4; c++)
    begin
      write_reg(cfg(14'h3, {3{c[1:0]}}, 3'b000, 5'h0), 6'h3f);
      check("low_flag", {47'h0, p1 > 4'h1 + c[3:0]}, {47'h0, ulow});
      check("high_flag", {47'h0, p1 > 4'h3 + c[3:0]}, {47'h0, uhigh});
      check("panic_flag", {47'h0, p1 > 4'h5 + c[3:0]}, {47'h0, upanic});
    end
    $display("Test count modes and watermarks done");
    spacing = 9'd10;
    m_en = 1'b1;
    m_delay = 4'h4;
    write_reg(cfg(14'h3fff, 6'h0, 3'b001, 5'h0), 6'h3f);
    drain();
    check("drain_count", {16'h0, 32'(p1) - 32'd1}, {16'h0, 32'(nd)});
    check("drain_pending", 48'h1, {44'h0, pending});
    check("drain_low", 48'h0, {47'h0, ulow});
    check("spacing_ok", 48'h1, {47'h0, gmin >= 10});
    check("drain_rank", 48'h0, {16'h0, 32'(same)});
    $display("Test all-rank refresh done");
    write_reg(cfg(14'h3, 6'h0, 3'b100, 5'h0), 6'h3f);
    wait_cycles(12);
    spacing = 9'd1;
    m_delay = 4'h0;
    // The model waits until the count is read, so no done pulse slips past the drain.
    m_en = 1'b0;
    write_reg(cfg(14'h3fff, 6'h0, 3'b011, 5'h0), 6'h3f);
    p1 = pending;
    check("indep_all", 48'h0, {47'h0, all});
    m_en = 1'b1;
    drain();
    check("indep_count", {16'h0, 32'(p1) * 32'd2 - 32'd2}, {16'h0, 32'(nd)});
    check("indep_rank", {16'h0, 32'(p1) - 32'd1}, {16'h0, 32'(same)});
    $display("Test independent refresh done");
    write_reg(cfg(14'h3fff, 6'h0, 3'b001, 5'h2), 6'h3f);
    creq = 1'b1;
    check("comp_early", 48'h0, {47'h0, cgrant});
    @(negedge clk);
    creq = 1'b0;
    check("comp_allrank", 48'h1, {47'h0, cgrant});
    @(negedge clk);
    check("comp_pulse", 48'h0, {47'h0, cgrant});
    write_reg(cfg(14'h3, 6'h0, 3'b011, 5'h2), 6'h3f);
    creq = 1'b1;
    @(negedge clk);
    creq = 1'b0;
    nd = 1;
    while (cgrant !== 1'b1 && nd < 40)
    begin
      @(negedge clk);
      nd++;
    end
    check("comp_wait", 48'h1, {47'h0, nd > 4 && nd < 14});
    $display("Test compensation done");
    finish_test();
  end
endmodule : dram_refresh_scheduler_ctrl_test
